// File: bench/nv_link_asserts.sv
// Checker for the link between host and device ends
`timescale 1ns/1ps
module nv_link_asserts (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic [8:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       stall
);
  // ======
  // Link properties
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire start_wr = reg_wr && reg_addr == 9'h18C && reg_wdata[1];
  property p_len; $rose(stall) |=> stall ##1 !stall; endproperty
  a_len: assert property (p_len) else $error("stall length");
  property p_cause; $rose(stall) |-> $past(start_wr); endproperty
  a_cause: assert property (p_cause) else $error("stall cause");
  property p_skip; stall |-> !reg_wr && !reg_rd; endproperty
  a_skip: assert property (p_skip) else $error("order in stall");
  property p_slot; start_wr |=> (!reg_wr && !reg_rd) [*2]; endproperty
  a_slot: assert property (p_slot) else $error("slot used");
  property p_zero; reg_rd && !stall && reg_addr == 9'h18D |=> reg_rdata == 8'h00; endproperty
  a_zero: assert property (p_zero) else $error("unlock read");
  property p_hold; !reg_rd || stall |=> $stable(reg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("data moved");
  property p_pulse; reg_wr |=> !reg_wr; endproperty
  a_pulse: assert property (p_pulse) else $error("strobe width");
  property p_excl; reg_rd |-> !reg_wr; endproperty
  a_excl: assert property (p_excl) else $error("both strobes");
endmodule // nv_link_asserts

// File: bench/tb_top.sv
// Bench for the device end and host end joined by the link
`timescale 1ns/1ps
module tb_top;
  logic        aclk, aresetn, warm_resetn, wp, ch, cl, lo, irq, rd_allow, wr_allow, st_allow;
  logic        awvalid, wvalid, arvalid, awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, rsp;
  logic [3:0]  awaddr, araddr;
  logic [7:0]  d;
  logic [10:0] ext_addr;
  logic [31:0] wdata, rdata, x;
  int          fail_count = 0;
  int          comparisons = 0;
  nv_link_if link ();
  nv_self_access #(.POWER_UP_CYCLES(200)) i_nv_self_access (
    .aclk, .aresetn, .warm_resetn, .flash_write_protect_cfg(wp), .protect_cfg_high(ch),
    .protect_cfg_low(cl), .store_protect_cfg(~wp), .ext_addr,
    .ext_flash_read_allow(rd_allow), .ext_flash_write_allow(wr_allow),
    .ext_store_access_allow(st_allow), .write_complete_irq(irq), .link(link.device));
  nv_access_host i_nv_access_host (
    .aclk, .aresetn, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'h1),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'h1),
    .link(link.host));
  nv_link_asserts i_nv_link_asserts (
    .aclk, .aresetn, .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_rdata(link.reg_rdata),
    .stall(link.stall));
  // ======
  // Clock and bus tasks
  initial begin
    aclk = 1'h0;
    forever #10 aclk = ~aclk;
  end
  task automatic test_done();
    if (fail_count == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic axw(logic [3:0] a, logic [31:0] v);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    for (int n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) begin
        rsp = bresp;
        return;
      end
    end
    fail_count++;
    test_done();
  endtask
  task automatic axr(logic [3:0] a);
    araddr <= a;
    arvalid <= 1'h1;
    for (int n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) begin
        x = rdata;
        rsp = rresp;
        return;
      end
    end
    fail_count++;
    test_done();
  endtask
  task automatic put(logic [8:0] o, logic [7:0] v);
    axw(4'h0, {15'h0000, v, o});
  endtask
  task automatic get(logic [8:0] o);
    axw(4'h0, {15'h0001, 8'h00, o});
    axr(4'h4);
    d = x[15:8];
  endtask
  task automatic rst(logic [2:0] c);
    {wp, ch, cl} <= c;
    aresetn <= 1'h0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    @(posedge aclk);
  endtask
  task automatic wr_word(logic [10:0] a, logic [13:0] v, logic [7:0] c);
    put(9'h10D, a[7:0]);
    put(9'h10F, {5'h00, a[10:8]});
    put(9'h10C, v[7:0]);
    put(9'h10E, {2'h0, v[13:8]});
    put(9'h18C, c);
    put(9'h18D, 8'h55);
    put(9'h18D, 8'hAA);
    put(9'h18C, c | 8'h02);
  endtask
  // ======
  // Scenarios
  task automatic s_power();
    rst(3'h7);
    get(9'h18C);
    chk("ctl", 8'h00, d & 8'h0F);
    wr_word(11'h005, 14'h0012, 8'h04);
    get(9'h00D);
    chk("early", 8'h00, d & 8'h10);
    repeat (200) @(posedge aclk);
    wr_word(11'h005, 14'h0012, 8'h04);
    get(9'h00D);
    chk("store", 8'h10, d & 8'h10);
    axr(4'h0);
    chk("echo", 32'h0002_000D, x);
    axw(4'h8, 32'h0);
    chk("bad wr", 2'h2, rsp);
    axr(4'h8);
    chk("bad rd", 2'h2, rsp);
  endtask
  task automatic s_flash();
    rst(3'h4);
    put(9'h08D, 8'h10);
    wr_word(11'h7FF, 14'h3A5C, 8'h84);
    axr(4'h4);
    chk("stall", 1'h1, x[1]);
    get(9'h00D);
    chk("flag", 8'h10, d & 8'h10);
    chk("irq", 1'h1, irq);
    get(9'h18C);
    chk("starts", 8'h00, d & 8'h03);
    get(9'h18D);
    chk("unlock", 8'h00, d);
    chk("ext", 2'h0, {rd_allow, wr_allow});
    put(9'h10C, 8'h00);
    put(9'h10E, 8'h00);
    put(9'h18C, 8'h81);
    get(9'h10C);
    chk("low", 8'h5C, d);
    get(9'h10E);
    chk("high", 8'h3A, d);
  endtask
  task automatic s_unlock();
    put(9'h00D, 8'h00);
    put(9'h18C, 8'h84);
    put(9'h18D, 8'h55);
    put(9'h10C, 8'h11);
    put(9'h18D, 8'hAA);
    put(9'h18C, 8'h86);
    get(9'h00D);
    chk("broken", 8'h00, d & 8'h10);
    put(9'h18C, 8'h80);
    put(9'h18D, 8'h55);
    put(9'h18D, 8'hAA);
    put(9'h18C, 8'h86);
    get(9'h00D);
    chk("joint", 8'h00, d & 8'h10);
    put(9'h18C, 8'h84);
    put(9'h18D, 8'h55);
    put(9'h18D, 8'hAA);
    fork
      put(9'h18C, 8'h86);
      begin
        repeat (5) @(posedge aclk);
        warm_resetn <= 1'h0;
        @(posedge aclk);
        warm_resetn <= 1'h1;
      end
    join
    get(9'h18C);
    chk("warm", 8'h88, d & 8'h8F);
    get(9'h10C);
    chk("kept", 8'h11, d);
  endtask
  task automatic s_protect();
    logic [13:0] tc [6];
    tc = '{14'h3FFF, 14'h1800, 14'h2FFF, 14'h2810, 14'h37FF, 14'h33FF};
    foreach (tc[i]) begin
      rst(tc[i][13:11]);
      ext_addr <= tc[i][10:0];
      wr_word(tc[i][10:0], 14'h1234, 8'h84);
      get(9'h00D);
      lo = tc[i][10:0] < 11'h400;
      chk("wr", {wp & ((ch == cl) | lo), 4'h0}, d & 8'h10);
      chk("ext rd", (ch & cl) | ((ch ^ cl) & lo), rd_allow);
      chk("ext wr", ch & cl, wr_allow);
      chk("ext st", wp & ch & cl, st_allow);
    end
  endtask
  initial begin
    {aresetn, warm_resetn, wp, ch, cl, awvalid, wvalid, arvalid} = 8'h40;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0;
    ext_addr = 11'h000;
    s_power();
    s_flash();
    s_unlock();
    s_protect();
    test_done();
  end
endmodule // tb_top

// File: design/nv_access_host.sv
// Processor-side end: AXI4-Lite slave that issues register orders on the link
`timescale 1ns/1ps
`include "nv_access_regs.svh"
module nv_access_host
  import nv_access_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  nv_link_if.host          link
);
  // ==========================================================
  // State
  host_state_type st_ff;
  logic           aw_ff;
  logic           w_ff;
  logic [3:0]     awaddr_ff;
  logic [31:0]    wdata_ff;
  logic           awready_ff;
  logic           wready_ff;
  logic           bvalid_ff;
  logic [1:0]     bresp_ff;
  logic           arready_ff;
  logic           rvalid_ff;
  logic [31:0]    rdata_ff;
  logic [1:0]     rresp_ff;
  logic [8:0]     addr_ff;
  logic [7:0]     wd_ff;
  logic           wr_ff;
  logic           rd_ff;
  logic           was_rd_ff;
  logic [7:0]     last_ff;
  logic           stall_seen_ff;

  // ==========================================================
  // Write address and data capture, in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ff      <= 1'b0;
      w_ff       <= 1'b0;
      awaddr_ff  <= 4'h0;
      wdata_ff   <= 32'h0000_0000;
      awready_ff <= 1'b0;
      wready_ff  <= 1'b0;
    end else begin
      awready_ff <= ~aw_ff & ~awready_ff & s_axi_awvalid;
      wready_ff  <= ~w_ff & ~wready_ff & s_axi_wvalid;
      if (awready_ff && s_axi_awvalid) begin
        aw_ff     <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end else if (st_ff == H_RESP && s_axi_bready) begin
        aw_ff <= 1'b0;
      end
      if (wready_ff && s_axi_wvalid) begin
        w_ff     <= 1'b1;
        wdata_ff <= s_axi_wdata;
      end else if (st_ff == H_RESP && s_axi_bready) begin
        w_ff <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Order sequencer: one order at a time, none while stalled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff     <= H_IDLE;
      addr_ff   <= 9'h000;
      wd_ff     <= 8'h00;
      wr_ff     <= 1'b0;
      rd_ff     <= 1'b0;
      was_rd_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `RESP_OKAY;
      last_ff   <= 8'h00;
    end else begin
      case (st_ff)
        H_IDLE: begin
          if (aw_ff && w_ff && !link.stall) begin // see [RULE_08]
            if (awaddr_ff == `AXI_OFF_COMMAND && s_axi_wstrb != 4'h0) begin
              addr_ff   <= wdata_ff[`CMD_BIT_ADDR_LSB +: 9];
              wd_ff     <= wdata_ff[`CMD_BIT_DATA_LSB +: 8]; // see [RULE_01] [RULE_04] [RULE_19]
              rd_ff     <= wdata_ff[`CMD_BIT_READ];
              wr_ff     <= ~wdata_ff[`CMD_BIT_READ]; // see [RULE_05]
              was_rd_ff <= wdata_ff[`CMD_BIT_READ];
              bresp_ff  <= `RESP_OKAY;
              st_ff     <= H_ISSUE;
            end else begin
              bresp_ff  <= `RESP_SLVERR;
              bvalid_ff <= 1'b1;
              st_ff     <= H_RESP;
            end
          end
        end
        H_ISSUE: begin
          wr_ff <= 1'b0;
          rd_ff <= 1'b0;
          st_ff <= H_WAIT;
        end
        H_WAIT: begin
          if (was_rd_ff) begin
            last_ff <= link.reg_rdata;
          end
          bvalid_ff <= 1'b1;
          st_ff     <= H_RESP;
        end
        H_RESP: begin
          if (s_axi_bready) begin
            bvalid_ff <= 1'b0;
            st_ff     <= H_IDLE;
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stall_seen_ff <= 1'b0;
    end else if (link.stall) begin
      stall_seen_ff <= 1'b1;
    end else if (s_axi_arvalid && arready_ff && s_axi_araddr == `AXI_OFF_STATUS) begin
      stall_seen_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_ff <= 1'b0;
      rvalid_ff  <= 1'b0;
      rdata_ff   <= 32'h0000_0000;
      rresp_ff   <= `RESP_OKAY;
    end else begin
      arready_ff <= ~rvalid_ff & ~arready_ff & s_axi_arvalid;
      if (arready_ff && s_axi_arvalid) begin
        rvalid_ff <= 1'b1;
        case (s_axi_araddr)
          `AXI_OFF_COMMAND: begin
            rdata_ff <= {14'h0000, was_rd_ff, wd_ff, addr_ff};
            rresp_ff <= `RESP_OKAY;
          end
          `AXI_OFF_STATUS: begin
            rdata_ff <= {16'h0000, last_ff, 6'h00, stall_seen_ff, st_ff != H_IDLE};
            rresp_ff <= `RESP_OKAY;
          end
          default: begin
            rdata_ff <= 32'h0000_0000;
            rresp_ff <= `RESP_SLVERR;
          end
        endcase
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  assign s_axi_awready  = awready_ff;
  assign s_axi_wready   = wready_ff;
  assign s_axi_bvalid   = bvalid_ff;
  assign s_axi_bresp    = bresp_ff;
  assign s_axi_arready  = arready_ff;
  assign s_axi_rvalid   = rvalid_ff;
  assign s_axi_rdata    = rdata_ff;
  assign s_axi_rresp    = rresp_ff;
  assign link.reg_addr  = addr_ff;
  assign link.reg_wdata = wd_ff;
  assign link.reg_wr    = wr_ff;
  assign link.reg_rd    = rd_ff;
endmodule // nv_access_host

// File: design/nv_access_pkg.sv
// Types of the two ends of the self-access link: device operation and unlock states, host states
package nv_access_pkg;
  typedef enum logic [1:0] {
    OP_IDLE  = 2'b00,
    OP_READ  = 2'b01,
    OP_WRITE = 2'b10
  } op_state_type;
  typedef enum logic [1:0] {
    UNL_IDLE  = 2'b00,
    UNL_FIRST = 2'b01,
    UNL_ARMED = 2'b11
  } unlock_state_type;
  typedef enum logic [1:0] {
    H_IDLE  = 2'b00,
    H_ISSUE = 2'b01,
    H_WAIT  = 2'b11,
    H_RESP  = 2'b10
  } host_state_type;
endpackage

// File: design/nv_access_regs.svh
// Offsets, bit positions, codes and timing counts of the self-access controller
`ifndef NV_ACCESS_REGS_SVH
`define NV_ACCESS_REGS_SVH
// ==========================================================
// Register offsets on the device register port
`define OFF_PERIPHERAL_FLAG_B   9'h00D
`define OFF_PERIPHERAL_ENABLE_B 9'h08D
`define OFF_NV_DATA_LOW         9'h10C
`define OFF_NV_ADDRESS_LOW      9'h10D
`define OFF_NV_DATA_HIGH        9'h10E
`define OFF_NV_ADDRESS_HIGH     9'h10F
`define OFF_NV_CONTROL          9'h18C
`define OFF_NV_UNLOCK_PORT      9'h18D
// ==========================================================
// Control and flag bit positions
`define BIT_PROGRAM_MEMORY_SELECT 7
`define BIT_WRITE_ERROR_FLAG      3
`define BIT_WRITE_ENABLE          2
`define BIT_WRITE_START           1
`define BIT_READ_START            0
`define BIT_WRITE_COMPLETE        4
// ==========================================================
// Unlock codes, protection and timing
`define UNLOCK_FIRST            8'h55
`define UNLOCK_SECOND           8'hAA
`define PROTECT_BOUNDARY        11'h400
`define FETCH_CYCLES            2'h2
`define FLASH_WRITE_CYCLES      2'h2
`define CLK_PERIOD_NS           20
`define POWER_UP_TIMER_MS       72
`define POWER_UP_TIMER_CYCLES   ((`POWER_UP_TIMER_MS * 1000000) / `CLK_PERIOD_NS)
// ==========================================================
// Controller register map over AXI4-Lite
`define AXI_OFF_COMMAND         4'h0
`define AXI_OFF_STATUS          4'h4
`define CMD_BIT_READ            17
`define CMD_BIT_ADDR_LSB        0
`define CMD_BIT_DATA_LSB        9
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2
`endif

// File: design/nv_link_if.sv
// Register port between the processor side and the self-access controller
`timescale 1ns/1ps
interface nv_link_if;
  logic [8:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_wr;
  logic       reg_rd;
  logic [7:0] reg_rdata;
  logic       stall;
  modport device (
    input  reg_addr, reg_wdata, reg_wr, reg_rd,
    output reg_rdata, stall
  );
  modport host (
    output reg_addr, reg_wdata, reg_wr, reg_rd,
    input  reg_rdata, stall
  );
endinterface

// File: design/nv_self_access.sv
// Program flash and data store self-access controller, device end
// What this block does
// [RULE_01] Reads load address, select flash, set read-start
// [RULE_02] Read word lands after two fetch cycles
// [RULE_03] Data registers hold last word until replaced
// [RULE_04] Writes load address, data, select, write-start
// [RULE_05] Write needs enable, 55h, AAh, then write-start
// [RULE_06] Flash write stalls execution two cycles
// [RULE_07] Accesses during stall are ignored, resume third
// [RULE_08] Software places idle slots after write-start
// [RULE_09] Full or no protection: write anywhere if enabled
// [RULE_10] Partial protection: only unprotected words writable
// [RULE_11] Power-up clears enable, timer blocks store writes
// [RULE_12] Protect configuration unchangeable by self-writes
// [RULE_13] Protect controls block external serial access
// [RULE_14] Processor always reaches the data store
// [RULE_15] Processor always reads program flash
// [RULE_16] Flash write needs protect cfg and location check
// [RULE_17] External reads and writes follow protect table
// [RULE_18] Unlock port stores nothing, reads zero
// [RULE_19] Software writes zero to reserved flag bits
// [RULE_20] Start bits set by software, cleared by hardware
// [RULE_21] Write end clears start, sets complete flag
// [RULE_22] Warm reset mid-write sets error, keeps registers
// [RULE_23] Write-start needs enable from earlier access
// [RULE_24] Any other write restarts the unlock sequence
`timescale 1ns/1ps
`include "nv_access_regs.svh"
module nv_self_access
  import nv_access_pkg::*;
#(
  parameter int POWER_UP_CYCLES = `POWER_UP_TIMER_CYCLES
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        warm_resetn,
  input  wire logic        flash_write_protect_cfg,
  input  wire logic        protect_cfg_high,
  input  wire logic        protect_cfg_low,
  input  wire logic        store_protect_cfg,
  input  wire logic [10:0] ext_addr,
  output logic             ext_flash_read_allow,
  output logic             ext_flash_write_allow,
  output logic             ext_store_access_allow,
  output logic             write_complete_irq,
  nv_link_if.device        link
);
  // ==========================================================
  // Storage
  logic [13:0]      flash_mem [2048];
  logic [7:0]       store_mem [64];
  logic [7:0]       addr_lo_ff, addr_hi_ff, data_lo_ff, rdata_ff;
  logic [5:0]       data_hi_ff;
  logic             pgd_ff, write_error_flag_ff, write_enable_ff, wr_ff, rd_ff, flag_ff, enable_ff;
  logic             wp_cfg_ff, cph_cfg_ff, cpl_cfg_ff, spc_cfg_ff;
  logic [21:0]      pwrt_ff;
  logic [1:0]       cnt_ff;
  logic             stall_ff, irq_ff, ext_rd_ff, ext_wr_ff, ext_st_ff;
  op_state_type     op_ff;
  unlock_state_type unl_ff;
  logic [10:0]      word_addr;
  logic             partial, flash_ok, wr_ctl, go_write, go_read, acc_wr, acc_rd, ext_prot;
  assign word_addr = {addr_hi_ff[2:0], addr_lo_ff};
  assign partial   = cph_cfg_ff ^ cpl_cfg_ff;
  // Self-write permission by protect configuration
  assign flash_ok  = wp_cfg_ff & (~partial | (word_addr < `PROTECT_BOUNDARY)); // see [RULE_09] [RULE_10] [RULE_16]
  assign acc_wr    = link.reg_wr & ~stall_ff; // see [RULE_07]
  assign acc_rd    = link.reg_rd & ~stall_ff; // see [RULE_07]
  assign wr_ctl    = acc_wr & (link.reg_addr == `OFF_NV_CONTROL);
  // Write-start needs armed unlock, earlier enable and permission
  assign go_write  = wr_ctl & link.reg_wdata[`BIT_WRITE_START] & (op_ff == OP_IDLE)
                   & (unl_ff == UNL_ARMED) & write_enable_ff
                   & (pgd_ff ? flash_ok : (pwrt_ff == '0)); // see [RULE_05] [RULE_23] [RULE_11]
  assign go_read   = wr_ctl & link.reg_wdata[`BIT_READ_START] & (op_ff == OP_IDLE)
                   & ~go_write; // see [RULE_01] [RULE_14] [RULE_15]
  assign ext_prot  = (ext_addr >= `PROTECT_BOUNDARY);
  // ==========================================================
  // Configuration capture, only at power-on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp_cfg_ff  <= flash_write_protect_cfg; // see [RULE_12]
      cph_cfg_ff <= protect_cfg_high;
      cpl_cfg_ff <= protect_cfg_low;
      spc_cfg_ff <= store_protect_cfg;
    end
  end
  // ==========================================================
  // Power-up timer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwrt_ff <= 22'(POWER_UP_CYCLES); // see [RULE_11]
    end else if (pwrt_ff != '0) begin
      pwrt_ff <= pwrt_ff - 22'h1;
    end
  end
  // ==========================================================
  // Unlock detector
  always_ff @(posedge aclk) begin
    if (!aresetn || !warm_resetn) begin
      unl_ff <= UNL_IDLE;
    end else if (acc_wr) begin
      case (unl_ff)
        UNL_IDLE:  unl_ff <= (link.reg_addr == `OFF_NV_UNLOCK_PORT
                             && link.reg_wdata == `UNLOCK_FIRST) ? UNL_FIRST : UNL_IDLE;
        UNL_FIRST: unl_ff <= (link.reg_addr == `OFF_NV_UNLOCK_PORT
                             && link.reg_wdata == `UNLOCK_SECOND) ? UNL_ARMED : UNL_IDLE;
        default:   unl_ff <= UNL_IDLE; // see [RULE_24]
      endcase
    end
  end
  // ==========================================================
  // Operation sequencer and stall
  always_ff @(posedge aclk) begin
    if (!aresetn || !warm_resetn) begin
      op_ff    <= OP_IDLE;
      cnt_ff   <= 2'h0;
      stall_ff <= 1'b0;
    end else begin
      case (op_ff)
        OP_IDLE: begin
          if (go_write) begin
            op_ff    <= OP_WRITE;
            cnt_ff   <= `FLASH_WRITE_CYCLES;
            stall_ff <= pgd_ff; // see [RULE_06]
          end else if (go_read) begin
            op_ff  <= OP_READ;
            cnt_ff <= `FETCH_CYCLES; // see [RULE_02]
          end
        end
        OP_READ, OP_WRITE: begin
          cnt_ff <= cnt_ff - 2'h1;
          if (cnt_ff == 2'h1) begin
            op_ff    <= OP_IDLE;
            stall_ff <= 1'b0; // see [RULE_07]
          end
        end
        default: op_ff <= OP_IDLE;
      endcase
    end
  end
  // ==========================================================
  // Control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pgd_ff   <= 1'b0;
      write_error_flag_ff <= 1'b0;
      write_enable_ff  <= 1'b0; // see [RULE_11]
      wr_ff    <= 1'b0;
      rd_ff    <= 1'b0;
    end else if (!warm_resetn) begin
      if (op_ff == OP_WRITE) begin
        write_error_flag_ff <= 1'b1; // see [RULE_22]
      end
      write_enable_ff <= 1'b0;
      wr_ff   <= 1'b0;
      rd_ff   <= 1'b0;
    end else begin
      if (wr_ctl) begin
        write_enable_ff  <= link.reg_wdata[`BIT_WRITE_ENABLE];
        write_error_flag_ff <= link.reg_wdata[`BIT_WRITE_ERROR_FLAG];
        if (op_ff == OP_IDLE) begin
          pgd_ff <= link.reg_wdata[`BIT_PROGRAM_MEMORY_SELECT];
        end
      end
      // Software only sets; completion clears
      if (go_write) begin
        wr_ff <= 1'b1; // see [RULE_20]
      end else if (op_ff == OP_WRITE && cnt_ff == 2'h1) begin
        wr_ff <= 1'b0; // see [RULE_21]
      end
      if (go_read) begin
        rd_ff <= 1'b1; // see [RULE_20]
      end else if (op_ff == OP_READ && cnt_ff == 2'h1) begin
        rd_ff <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Address and data registers, memories
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      addr_lo_ff <= 8'h00;
      addr_hi_ff <= 8'h00;
      data_lo_ff <= 8'h00;
      data_hi_ff <= 6'h00;
    end else if (warm_resetn) begin
      if (op_ff == OP_READ && cnt_ff == 2'h1) begin
        if (pgd_ff) begin
          data_lo_ff <= flash_mem[word_addr][7:0]; // see [RULE_02] [RULE_15]
          data_hi_ff <= flash_mem[word_addr][13:8];
        end else begin
          data_lo_ff <= store_mem[addr_lo_ff[5:0]]; // see [RULE_14]
        end
      end else if (acc_wr) begin
        case (link.reg_addr)
          `OFF_NV_ADDRESS_LOW:  addr_lo_ff <= link.reg_wdata;
          `OFF_NV_ADDRESS_HIGH: addr_hi_ff <= link.reg_wdata;
          `OFF_NV_DATA_LOW:     data_lo_ff <= link.reg_wdata; // see [RULE_03]
          `OFF_NV_DATA_HIGH:    data_hi_ff <= link.reg_wdata[5:0];
          default: ;
        endcase
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (aresetn && warm_resetn && op_ff == OP_WRITE && cnt_ff == 2'h1) begin
      if (pgd_ff) begin
        flash_mem[word_addr] <= {data_hi_ff, data_lo_ff};
      end else begin
        store_mem[addr_lo_ff[5:0]] <= data_lo_ff;
      end
    end
  end
  // ==========================================================
  // Completion flag and enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff   <= 1'b0;
      enable_ff <= 1'b0;
      irq_ff    <= 1'b0;
    end else begin
      if (warm_resetn && op_ff == OP_WRITE && cnt_ff == 2'h1) begin
        flag_ff <= 1'b1; // see [RULE_21]
      end else if (acc_wr && link.reg_addr == `OFF_PERIPHERAL_FLAG_B) begin
        flag_ff <= link.reg_wdata[`BIT_WRITE_COMPLETE];
      end
      if (acc_wr && link.reg_addr == `OFF_PERIPHERAL_ENABLE_B) begin
        enable_ff <= link.reg_wdata[`BIT_WRITE_COMPLETE];
      end
      irq_ff <= flag_ff & enable_ff;
    end
  end
  // ==========================================================
  // Register read port
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_ff <= 8'h00;
    end else if (acc_rd) begin
      case (link.reg_addr)
        `OFF_NV_ADDRESS_LOW:      rdata_ff <= addr_lo_ff;
        `OFF_NV_ADDRESS_HIGH:     rdata_ff <= addr_hi_ff;
        `OFF_NV_DATA_LOW:         rdata_ff <= data_lo_ff;
        `OFF_NV_DATA_HIGH:        rdata_ff <= {2'h0, data_hi_ff};
        `OFF_NV_CONTROL:          rdata_ff <= {pgd_ff, 3'h0, write_error_flag_ff, write_enable_ff, wr_ff, rd_ff};
        `OFF_PERIPHERAL_FLAG_B:   rdata_ff <= {3'h0, flag_ff, 4'h0};
        `OFF_PERIPHERAL_ENABLE_B: rdata_ff <= {3'h0, enable_ff, 4'h0};
        default:                  rdata_ff <= 8'h00; // see [RULE_18]
      endcase
    end
  end
  // ==========================================================
  // External serial programming permissions
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_rd_ff <= 1'b0;
      ext_wr_ff <= 1'b0;
      ext_st_ff <= 1'b0;
    end else begin
      ext_rd_ff <= (cph_cfg_ff & cpl_cfg_ff) | (partial & ~ext_prot); // see [RULE_17]
      ext_wr_ff <= cph_cfg_ff & cpl_cfg_ff; // see [RULE_17]
      ext_st_ff <= ~spc_cfg_ff & cph_cfg_ff & cpl_cfg_ff; // see [RULE_13]
    end
  end
  assign link.reg_rdata         = rdata_ff;
  assign link.stall             = stall_ff;
  assign ext_flash_read_allow   = ext_rd_ff;
  assign ext_flash_write_allow  = ext_wr_ff;
  assign ext_store_access_allow = ext_st_ff;
  assign write_complete_irq     = irq_ff;
endmodule // nv_self_access
